// >>> logic/iec_pkg.sv
// Package: register map, field positions and carriers for interrupt edge/enable control
package iec_pkg;
    // ------------------------------------------------------------
    // Register byte addresses (AXI4-Lite, one word each)
    // ------------------------------------------------------------
    localparam logic [3:0] IEC_ADDR_EDGE_SEL = 4'h0;
    localparam logic [3:0] IEC_ADDR_ENABLE_FIRST = 4'h4;
    localparam logic [3:0] IEC_ADDR_ENABLE_SECOND = 4'h8;
    localparam logic [3:0] IEC_ADDR_PENDING = 4'hc;
    // ------------------------------------------------------------
    // Reset values and fixed bits
    // ------------------------------------------------------------
    localparam logic [7:0] IEC_EDGE_SEL_RESET = 8'he0;
    localparam logic [7:0] IEC_EDGE_SEL_FIXED_ONES = 8'he0;
    localparam logic [7:0] IEC_EDGE_SEL_WRITABLE = 8'h1f;
    localparam logic [7:0] IEC_ENABLE_RESET = 8'h00;
    localparam logic [1:0] IEC_RESP_OKAY = 2'h0;
    localparam logic [1:0] IEC_RESP_SLVERR = 2'h2;
    // ------------------------------------------------------------
    // Field positions, first enable register
    // ------------------------------------------------------------
    localparam int IEC_EN1_TIMER_A = 7;
    localparam int IEC_EN1_SERIAL_ONE = 6;
    localparam int IEC_EN1_WAKEUP = 5;
    // Second enable register
    localparam int IEC_EN2_DIRECT_TRANSFER = 7;
    localparam int IEC_EN2_CONVERTER = 6;
    localparam int IEC_EN2_TIMER_G = 4;
    localparam int IEC_EN2_TIMER_F_HIGH = 3;
    localparam int IEC_EN2_TIMER_F_LOW = 2;
    localparam int IEC_EN2_TIMER_C = 1;
    localparam int IEC_EN2_ASYNC_COUNTER = 0;
    // Edge-select: timer F shares pin3, timer C shares pin1, converter trigger pin4
    localparam int IEC_EDGE_TIMER_F = 3;
    localparam int IEC_EDGE_TIMER_C = 1;
    localparam int IEC_EDGE_CONVERTER = 4;
    localparam int IEC_NUM_EXT_PINS = 5;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic direct_transfer;
        logic converter;
        logic timer_g;
        logic timer_f_high;
        logic timer_f_low;
        logic timer_c;
        logic async_counter;
        logic timer_a;
        logic serial_one;
        logic wakeup;
    } iec_periph_req_t;
    typedef struct packed {
        logic [IEC_NUM_EXT_PINS-1:0] ext_pin;
        iec_periph_req_t periph;
    } iec_cpu_req_t;
endpackage

// >>> logic/iec_edge_detect.sv
// Pin synchroniser and selectable-edge detector for one input
`timescale 1ns/1ns
module iec_edge_detect
    import iec_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic pin_in, // Asynchronous pin level
    input wire logic rising_sel, // 1 rising, 0 falling
    output logic edge_pulse // One-cycle detected edge
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    // ------------------------------------------------------------
    // Two-stage synchroniser plus history sample
    // ------------------------------------------------------------
    // Reset to high so an idle high pin sees no false fall
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
            prev_reg <= 1'b1;
        end else begin
            sync1_reg <= pin_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    // Compare consecutive synchronised samples only
    always_comb begin
        edge_pulse = rising_sel ? (sync2_reg & ~prev_reg) : (~sync2_reg & prev_reg);
    end
    AST_EDGE_ONE_CYCLE: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_pulse |=> !edge_pulse) else $error("edge pulse longer than one cycle");
endmodule

// >>> logic/iec_ctrl.sv
// Interrupt edge-select and enable control with AXI4-Lite register slave
// Function
// - Edge bit 3 picks pin3 and timer F event edge; 0 falling, 1 rising.
// - Edge bit 2 picks pin2 edge; 0 falling is reset, 1 rising.
// - Edge bit 1 picks pin1 and timer C event edge; 0 falling, 1 rising.
// - Edge bit 0 picks pin0 edge; 0 falling is reset, 1 rising.
// - First enable register: 8-bit read/write, all zero after reset.
// - First enable bit 7 gates timer A overflow requests.
// - First enable bit 6 gates serial unit one transfer-complete requests.
// - First enable bit 5 gates all eight wakeup pin requests together.
// - First enable bits 4..0 gate the same-numbered external pin requests.
// - Second enable register: 8-bit read/write, all zero after reset.
// - Second enable bit 7 gates direct-transfer requests.
// - Second enable bit 6 gates converter requests.
// - Second enable bit 5 is spare storage, reads back, resets zero.
// - Second enable bit 4 gates timer G capture and overflow requests.
// - Second enable bit 3 gates timer FH compare and overflow requests.
// - Second enable bit 2 gates timer FL compare and overflow requests.
// - Second enable bit 1 gates timer C overflow and underflow requests.
// - Second enable bit 0 gates asynchronous event counter requests.
// - Edge register bits 7..5 always read one and ignore writes.
// - Edge bit 4 picks pin4 and converter trigger edge; 0 falling.
`timescale 1ns/1ns
module iec_ctrl
    import iec_pkg::*;
#(
    parameter int NUM_WAKE = 8 // Wakeup pin count
) (
    input wire logic aclk, // System clock, 25 MHz
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [3:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [3:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic [IEC_NUM_EXT_PINS-1:0] ext_int_pin_n, // External interrupt pins
    input wire logic [IEC_NUM_EXT_PINS-1:0] ext_pend_clr, // Pin pending clears
    input wire logic [NUM_WAKE-1:0] wake_pin_req, // Wakeup pending flags
    input wire iec_periph_req_t periph_pend, // Peripheral pending flags
    output logic [IEC_NUM_EXT_PINS-1:0] ext_pend, // Pin pending flags
    output logic timer_f_rising, // Timer F event edge
    output logic timer_c_rising, // Timer C event edge
    output logic converter_trig_rising, // Converter trigger edge
    output iec_cpu_req_t cpu_req // Gated requests to CPU
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [4:0] edge_sel_reg;
    logic [7:0] int_enable_first_reg;
    logic [7:0] int_enable_second_reg;
    logic [IEC_NUM_EXT_PINS-1:0] ext_pend_reg;
    logic [IEC_NUM_EXT_PINS-1:0] edge_pulse;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [3:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;
    logic wr_hit;
    logic rd_fire;

    // Byte-lane-0 write: registers are 8 bits wide
    function automatic logic lane0(input logic [3:0] strb);
        return strb[0];
    endfunction

    // ------------------------------------------------------------
    // AXI4-Lite write path: address and data taken in either order
    // ------------------------------------------------------------
    assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign wr_hit = (awaddr_reg == IEC_ADDR_EDGE_SEL) || (awaddr_reg == IEC_ADDR_ENABLE_FIRST) ||
                    (awaddr_reg == IEC_ADDR_ENABLE_SECOND) || (awaddr_reg == IEC_ADDR_PENDING);

    // Ready is high while the holding slot is empty and no write response is pending
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            awaddr_reg <= 4'h0;
            wdata_reg <= 32'h0;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_hold_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_hold_reg <= 1'b0;
            end
            s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Write response; unmapped address answers SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= IEC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? IEC_RESP_OKAY : IEC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Only low five edge bits are stored; top three are constant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            edge_sel_reg <= IEC_EDGE_SEL_RESET[4:0];
        end else if (wr_fire && lane0(wstrb_reg) && awaddr_reg == IEC_ADDR_EDGE_SEL) begin
            edge_sel_reg <= wdata_reg[4:0] & IEC_EDGE_SEL_WRITABLE[4:0];
        end
    end

    // First enable register, full 8 bits stored
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_enable_first_reg <= IEC_ENABLE_RESET;
        end else if (wr_fire && lane0(wstrb_reg) && awaddr_reg == IEC_ADDR_ENABLE_FIRST) begin
            int_enable_first_reg <= wdata_reg[7:0];
        end
    end

    // Second enable register; spare bit 5 stored like the rest
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_enable_second_reg <= IEC_ENABLE_RESET;
        end else if (wr_fire && lane0(wstrb_reg) && awaddr_reg == IEC_ADDR_ENABLE_SECOND) begin
            int_enable_second_reg <= wdata_reg[7:0];
        end
    end

    // ------------------------------------------------------------
    // External pin edge detection and pending flags
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < IEC_NUM_EXT_PINS; gi++) begin : g_pin
            iec_edge_detect u_iec_edge_detect (
                .aclk(aclk),
                .aresetn(aresetn),
                .pin_in(ext_int_pin_n[gi]),
                .rising_sel(edge_sel_reg[gi]),
                .edge_pulse(edge_pulse[gi])
            );
        end
    endgenerate

    // Set beats clear so an edge in the clear cycle survives; write 0 clears
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_pend_reg <= '0;
        end else begin
            ext_pend_reg <= edge_pulse | (ext_pend_reg & ~ext_pend_clr &
                ~((wr_fire && lane0(wstrb_reg) && awaddr_reg == IEC_ADDR_PENDING) ?
                  ~wdata_reg[IEC_NUM_EXT_PINS-1:0] : '0));
        end
    end

    // ------------------------------------------------------------
    // Gated request outputs and shared edge selections
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_req <= '0;
            ext_pend <= '0;
            timer_f_rising <= 1'b0;
            timer_c_rising <= 1'b0;
            converter_trig_rising <= 1'b0;
        end else begin
            ext_pend <= ext_pend_reg;
            timer_f_rising <= edge_sel_reg[IEC_EDGE_TIMER_F];
            timer_c_rising <= edge_sel_reg[IEC_EDGE_TIMER_C];
            converter_trig_rising <= edge_sel_reg[IEC_EDGE_CONVERTER];
            cpu_req.ext_pin <= ext_pend_reg & int_enable_first_reg[IEC_NUM_EXT_PINS-1:0];
            cpu_req.periph.timer_a <= periph_pend.timer_a & int_enable_first_reg[IEC_EN1_TIMER_A];
            cpu_req.periph.serial_one <= periph_pend.serial_one &
                int_enable_first_reg[IEC_EN1_SERIAL_ONE];
            cpu_req.periph.wakeup <= (|wake_pin_req) & int_enable_first_reg[IEC_EN1_WAKEUP];
            cpu_req.periph.direct_transfer <= periph_pend.direct_transfer &
                int_enable_second_reg[IEC_EN2_DIRECT_TRANSFER];
            cpu_req.periph.converter <= periph_pend.converter & int_enable_second_reg[IEC_EN2_CONVERTER];
            cpu_req.periph.timer_g <= periph_pend.timer_g & int_enable_second_reg[IEC_EN2_TIMER_G];
            cpu_req.periph.timer_f_high <= periph_pend.timer_f_high &
                int_enable_second_reg[IEC_EN2_TIMER_F_HIGH];
            cpu_req.periph.timer_f_low <= periph_pend.timer_f_low &
                int_enable_second_reg[IEC_EN2_TIMER_F_LOW];
            cpu_req.periph.timer_c <= periph_pend.timer_c & int_enable_second_reg[IEC_EN2_TIMER_C];
            cpu_req.periph.async_counter <= periph_pend.async_counter &
                int_enable_second_reg[IEC_EN2_ASYNC_COUNTER];
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path: one-cycle answer after address taken
    // ------------------------------------------------------------
    assign rd_fire = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= IEC_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= IEC_RESP_OKAY;
                unique case (s_axi_araddr)
                    IEC_ADDR_EDGE_SEL: s_axi_rdata <= {24'h0, IEC_EDGE_SEL_FIXED_ONES[7:5], edge_sel_reg};
                    IEC_ADDR_ENABLE_FIRST: s_axi_rdata <= {24'h0, int_enable_first_reg};
                    IEC_ADDR_ENABLE_SECOND: s_axi_rdata <= {24'h0, int_enable_second_reg};
                    IEC_ADDR_PENDING: s_axi_rdata <= {27'h0, ext_pend_reg};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= IEC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_EDGE_FIXED_ONES: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire && s_axi_araddr == IEC_ADDR_EDGE_SEL |=> s_axi_rdata[7:5] == 3'h7)
        else $error("edge register top bits not read as one");
    AST_EN1_RESET: assert property (@(posedge aclk)
        !aresetn |=> int_enable_first_reg == 8'h00) else $error("first enable not cleared by reset");
    AST_EN2_RESET: assert property (@(posedge aclk)
        !aresetn |=> int_enable_second_reg == 8'h00) else $error("second enable not cleared by reset");
    AST_PIN_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> cpu_req.ext_pin == ($past(ext_pend_reg) & $past(int_enable_first_reg[4:0])))
        else $error("pin request not gated by pending and enable");
    AST_DISABLE_KEEPS_PEND: assert property (@(posedge aclk) disable iff (!aresetn)
        ext_pend_reg[0] && !ext_pend_clr[0] && !wr_fire |=> ext_pend_reg[0])
        else $error("pending lost without clear");
    AST_SET_WINS: assert property (@(posedge aclk) disable iff (!aresetn)
        edge_pulse[2] |=> ext_pend_reg[2]) else $error("edge did not set pending");
    AST_WAKE_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        !int_enable_first_reg[IEC_EN1_WAKEUP] |=> !cpu_req.periph.wakeup)
        else $error("wakeup passed while disabled");
    AST_TIMER_G_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
        periph_pend.timer_g && int_enable_second_reg[IEC_EN2_TIMER_G] |=> cpu_req.periph.timer_g)
        else $error("timer g request blocked while enabled");
    AST_EDGE_WRITE: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && wstrb_reg[0] && awaddr_reg == IEC_ADDR_EDGE_SEL |=> ##1 timer_f_rising == $past(wdata_reg[3], 2))
        else $error("timer f edge not following bit 3");
    AST_READ_ANSWER: assert property (@(posedge aclk) disable iff (!aresetn)
        rd_fire |=> s_axi_rvalid) else $error("read not answered in one cycle");
    COV_WRITE: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && wr_hit);
    COV_PIN_REQ: cover property (@(posedge aclk) disable iff (!aresetn) |cpu_req.ext_pin);
    COV_RISING: cover property (@(posedge aclk) disable iff (!aresetn) edge_pulse[3] && edge_sel_reg[3]);
endmodule

// >>> tb/iec_src_model.sv
// Request source model: pins and peripheral flags seen by the controller
`timescale 1ns/1ns
module iec_src_model
    import iec_pkg::*;
(
    input wire logic aclk, // System clock
    input wire logic aresetn, // Synchronous reset, active low
    input wire logic [4:0] pin_cmd, // Pin levels to present
    input wire logic [7:0] wake_cmd, // Wakeup flags to present
    input wire iec_periph_req_t pend_cmd, // Peripheral flags to present
    output logic [4:0] pin_lvl, // Driven pin levels
    output logic [7:0] wake_req, // Wakeup pending flags
    output iec_periph_req_t pend // Peripheral pending flags
);
    // Flags move on the clock like real flag registers; pins idle high
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_lvl <= 5'h1f;
            wake_req <= 8'h00;
            pend <= '0;
        end else begin
            pin_lvl <= pin_cmd;
            wake_req <= wake_cmd;
            pend <= pend_cmd;
            pend.wakeup <= 1'b0; // Wakeup group comes only from wake_req
        end
    end
endmodule

// >>> tb/iec_ctrl_tb.sv
// Self-checking bench for interrupt edge-select and enable control
`timescale 1ns/1ns
module iec_ctrl_tb
    import iec_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, tf_r, tc_r, cv_r;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [4:0] pin_cmd, pins, pend_clr, ext_pend;
    logic [7:0] wake_cmd, wake, e1, e2, ev, d;
    logic [1:0] r, wresp;
    iec_periph_req_t pend_cmd, pend, pv;
    iec_cpu_req_t cpu_req;
    int n_mismatch, checks_done;
    integer seed;

    iec_ctrl #(.NUM_WAKE(8)) u_iec_ctrl (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_int_pin_n(pins), .ext_pend_clr(pend_clr), .wake_pin_req(wake), .periph_pend(pend),
        .ext_pend(ext_pend), .timer_f_rising(tf_r), .timer_c_rising(tc_r),
        .converter_trig_rising(cv_r), .cpu_req(cpu_req));

    iec_src_model u_iec_src_model (.aclk(aclk), .aresetn(aresetn), .pin_cmd(pin_cmd),
        .wake_cmd(wake_cmd), .pend_cmd(pend_cmd), .pin_lvl(pins), .wake_req(wake), .pend(pend));

    // 25 MHz system clock
    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    // --------------------------------------------------
    // Compare, bus and expectation helpers
    // --------------------------------------------------
    task automatic chk_reg(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic chk_req(input string nm, input logic [9:0] exp, input logic [9:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [3:0] a, input logic [7:0] dt);
        logic aw, w;
        @(posedge aclk);
        aw = 1'b0;
        w = 1'b0;
        awaddr <= a;
        wdata <= {24'h0, dt};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && awready === 1'b1) begin
                aw = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w && wready === 1'b1) begin
                w = 1'b1;
                wvalid <= 1'b0;
            end
        end
        while (bvalid !== 1'b1) @(posedge aclk);
        wresp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] dt, output logic [1:0] rs);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (arready !== 1'b1) @(posedge aclk);
        arvalid <= 1'b0;
        @(posedge aclk);
        while (rvalid !== 1'b1) @(posedge aclk);
        dt = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
        rd(a, d, r);
        chk_reg("register read", exp, d);
    endtask

    // Gated peripheral requests expected from flags and enables
    function automatic iec_periph_req_t gate(input iec_periph_req_t p, input logic [7:0] w,
                                             input logic [7:0] a, input logic [7:0] b);
        iec_periph_req_t g;
        g.direct_transfer = p.direct_transfer & b[7];
        g.converter = p.converter & b[6];
        g.timer_g = p.timer_g & b[4];
        g.timer_f_high = p.timer_f_high & b[3];
        g.timer_f_low = p.timer_f_low & b[2];
        g.timer_c = p.timer_c & b[1];
        g.async_counter = p.async_counter & b[0];
        g.timer_a = p.timer_a & a[7];
        g.serial_one = p.serial_one & a[6];
        g.wakeup = (|w) & a[5];
        return g;
    endfunction

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // --------------------------------------------------
    // Scenarios
    // --------------------------------------------------
    initial begin
        seed = 25;
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, pend_clr, wake_cmd} = '0;
        wstrb = 4'hf;
        pin_cmd = 5'h1f;
        pend_cmd = '0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(IEC_ADDR_EDGE_SEL, 8'he0);
        rchk(IEC_ADDR_ENABLE_FIRST, 8'h00);
        rchk(IEC_ADDR_ENABLE_SECOND, 8'h00);
        wr(IEC_ADDR_EDGE_SEL, 8'h00);
        chk_reg("write resp", {6'h0, IEC_RESP_OKAY}, {6'h0, wresp});
        rchk(IEC_ADDR_EDGE_SEL, 8'he0);
        rd(4'h2, d, r);
        chk_reg("unmapped resp", {6'h0, IEC_RESP_SLVERR}, {6'h0, r});
        wr(4'h2, 8'hff);
        chk_reg("unmapped write resp", {6'h0, IEC_RESP_SLVERR}, {6'h0, wresp});
        // Lane 0 strobe off: the write must leave the register alone
        wstrb <= 4'he;
        wr(IEC_ADDR_ENABLE_FIRST, 8'hff);
        wstrb <= 4'hf;
        rchk(IEC_ADDR_ENABLE_FIRST, 8'h00);
        $display("register reset test done");
        // Random enables and flags; first pass all open, second all shut
        for (int i = 0; i < 16; i++) begin
            e1 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            e2 = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
            pv = (i < 2) ? 10'h3fe : 10'($random(seed));
            pv.wakeup = 1'b0;
            ev = (i < 2) ? 8'h80 : 8'($random(seed));
            wr(IEC_ADDR_ENABLE_FIRST, e1);
            wr(IEC_ADDR_ENABLE_SECOND, e2);
            rchk(IEC_ADDR_ENABLE_FIRST, e1);
            rchk(IEC_ADDR_ENABLE_SECOND, e2);
            pend_cmd <= pv;
            wake_cmd <= ev;
            repeat (4) @(posedge aclk);
            chk_req("cpu periph req", gate(pv, ev, e1, e2), cpu_req.periph);
        end
        $display("gating test done");
        // Each pin, each edge: wrong edge ignored, right edge pends, disable keeps it
        for (int p = 0; p < 5; p++) begin
            for (int s = 0; s < 2; s++) begin
                ev = 8'(s) << p;
                wr(IEC_ADDR_EDGE_SEL, ev);
                wr(IEC_ADDR_ENABLE_FIRST, 8'h01 << p);
                // Start level chosen so the first move is the unselected edge
                pin_cmd <= (s == 0) ? (5'h1f ^ (5'h01 << p)) : 5'h1f;
                repeat (10) @(posedge aclk);
                pend_clr <= 5'h1f;
                @(posedge aclk);
                pend_clr <= 5'h00;
                chk_reg("edge outputs", {5'h0, ev[4], ev[3], ev[1]}, {5'h0, cv_r, tf_r, tc_r});
                pin_cmd[p] <= ~s[0];
                repeat (10) @(posedge aclk);
                chk_reg("pin pending", 8'h00, {3'h0, ext_pend});
                pin_cmd[p] <= s[0];
                repeat (10) @(posedge aclk);
                chk_reg("pin pending", 8'h01 << p, {3'h0, ext_pend});
                chk_reg("cpu pin req", 8'h01 << p, {3'h0, cpu_req.ext_pin});
                wr(IEC_ADDR_ENABLE_FIRST, 8'h00);
                repeat (3) @(posedge aclk);
                chk_reg("cpu pin req", 8'h00, {3'h0, cpu_req.ext_pin});
                chk_reg("pin pending", 8'h01 << p, {3'h0, ext_pend});
                rchk(IEC_ADDR_PENDING, 8'h01 << p);
                wr(IEC_ADDR_PENDING, 8'h00);
                repeat (3) @(posedge aclk);
                chk_reg("pin pending", 8'h00, {3'h0, ext_pend});
            end
        end
        $display("pin edge test done");
        complete_run();
    end

    // Watchdog: the whole run needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        $display("[ERR] run length expected below 20000 cycles seen more");
        complete_run();
    end
endmodule
